// File: cad_card_model.sv
/*
 * Card side model for the decoder bench: answers reads with a value
 * made from the card address.
 * Assumes the decoder's registered card controls on the same clock.
 */
`timescale 1ns/1ps
module cad_card_model (
  input wire logic clk,
  input wire cad_pkg::cad_card_ctl_t ctl,
  output logic [15:0] d_out
);
  import cad_pkg::*;
  logic [15:0] last = 16'h0000;
  logic rd;
  // strict compares: unknown controls before reset must not poison last
  assign rd = ctl.ce1_b === 1'b0
    && (ctl.oe_b === 1'b0 || ctl.iord_b === 1'b0);
  // released bus flips each cycle so stale data never passes
  always_comb d_out = rd ? {5'h1a, ctl.addr} : ~last;
  always @(posedge clk) last <= d_out;
endmodule

// File: cad_decoder.sv
/*
 * Card ATA address decoder: package of constants and types, and the
 * decoder module that turns host bus cycles into card strobes, enables,
 * register-space select, card address and byte-swapped data lanes.
 * Assumes a big-endian host with a 16-bit data path whose inputs are
 * synchronous to MCLK; card outputs follow the host cycle one clock late.
 */
`timescale 1ns/1ps

package cad_pkg;
  // host address bit positions, little-endian numbering (bit 0 = LSB)
  localparam int WIN_LSB = 17;
  localparam logic [14:0] WIN_VAL = 15'h0014;
  localparam int CE2_POS = 16;
  localparam int CE1_POS = 15;
  localparam int IOS_POS = 14;
  localparam int MEMS_POS = 13;
  localparam int REG_POS = 12;
  localparam int A0_POS = 11;
  localparam int WORD_MSB = 10;
  localparam int WORD_LSB = 1;
  // window bases as seen by the host
  localparam logic [31:0] MEM_BASE = 32'h0028_5000;
  localparam logic [31:0] IO_BASE = 32'h0028_2000;
  // {io strobe, mem strobe, reg} address bits selecting each mode
  localparam logic [2:0] SEL_MEM = 3'h5;
  localparam logic [2:0] SEL_IO = 3'h2;
  // drive register word offsets on card A10-A1
  localparam logic [9:0] W_DATA = 10'h000;
  localparam logic [9:0] W_SECT = 10'h001;
  localparam logic [9:0] W_CYL = 10'h002;
  localparam logic [9:0] W_HEAD = 10'h003;
  localparam logic [9:0] W_ALT = 10'h007;

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_MEM = 2'b01,
    MODE_IO = 2'b10
  } cad_mode_t;

  typedef struct packed {
    logic ce1_b;
    logic ce2_b;
    logic iord_b;
    logic iowr_b;
    logic oe_b;
    logic we_b;
    logic reg_b;
    logic [10:0] addr;
  } cad_card_ctl_t;

  localparam cad_card_ctl_t CTL_IDLE = '{
    ce1_b: 1'b1, ce2_b: 1'b1, iord_b: 1'b1, iowr_b: 1'b1,
    oe_b: 1'b1, we_b: 1'b1, reg_b: 1'b1, addr: 11'h000};
endpackage

// Behaviour
// RULE_01 - two modes: memory-mapped and contiguous I/O
// RULE_02 - memory mode: OE/WE strobes, REG high
// RULE_03 - I/O mode: IORD/IOWR strobes, REG low
// RULE_04 - card signals taken from host address bits
// RULE_05 - drive registers selected by card word offset
// RULE_06 - data, sector, cylinder: both enables, 16-bit; code also decodes data with CE2 and A0 high on CE1 only
// RULE_07 - other registers: CE1 only, 8-bit
// RULE_08 - byte lanes crossed between host and card
// RULE_09 - host +0 byte is card even byte
// RULE_10 - decode only inside host chip-select zero
// RULE_11 - software opens card buffer gate first
// RULE_12 - unlisted addresses leave card signals idle
module cad_decoder (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic HOST_CHIP_SELECT_ZERO_B,
  input wire logic HOST_RD_B,
  input wire logic HOST_WR_B,
  input wire logic [31:0] HOST_ADDR,
  input wire logic [15:0] HOST_D_IN,
  output logic [15:0] HOST_D_OUT,
  output logic HOST_D_OE_B,
  input wire logic CARD_BUFFER_GATE,
  output cad_pkg::cad_card_ctl_t CARD_CTL,
  input wire logic [15:0] CARD_D_IN,
  output logic [15:0] CARD_D_OUT,
  output logic CARD_D_OE_B
);
  import cad_pkg::*;

  // big-endian host +0 byte sits on the upper lanes; card even byte low
  function automatic logic [15:0] swap_lanes(input logic [15:0] d);
    swap_lanes = {d[7:0], d[15:8]};
  endfunction

  // mode from the strobe/reg address bits inside the card window
  function automatic cad_mode_t mode_of(input logic [31:0] a);
    logic [2:0] sel;
    sel = {a[IOS_POS], a[MEMS_POS], a[REG_POS]};
    mode_of = MODE_NONE;
    if (a[31:WIN_LSB] == WIN_VAL && !a[CE1_POS]) begin
      if (sel == SEL_MEM) begin
        mode_of = MODE_MEM; // RULE_01
      end else if (sel == SEL_IO) begin
        mode_of = MODE_IO; // RULE_01
      end
    end
  endfunction

  // only the table's drive register decodes are legal
  function automatic logic reg_listed(input logic [31:0] a, input logic rd);
    logic [9:0] w;
    logic ce2;
    logic a0;
    w = a[WORD_MSB:WORD_LSB];
    ce2 = a[CE2_POS];
    a0 = a[A0_POS];
    reg_listed = 1'b0;
    unique case (w)
      W_DATA: reg_listed = (ce2 == a0); // RULE_05
      W_SECT, W_CYL: reg_listed = !ce2 && !a0; // RULE_05
      W_HEAD: reg_listed = ce2; // RULE_05
      W_ALT: reg_listed = ce2 && (!a0 || rd); // RULE_05
      default: reg_listed = 1'b0;
    endcase
  endfunction

  logic rd;
  logic wr;
  cad_mode_t mode;
  logic hit;
  cad_card_ctl_t ctl_reg, ctl_next;
  logic [15:0] host_dout_reg, host_dout_next;
  logic host_doe_b_reg, host_doe_b_next;
  logic [15:0] card_dout_reg, card_dout_next;
  logic card_doe_b_reg, card_doe_b_next;

  always_comb begin
    rd = !HOST_RD_B && HOST_WR_B;
    wr = !HOST_WR_B && HOST_RD_B;
    mode = mode_of(HOST_ADDR);
    // gate high keeps the card buffers shut; host must clear it first
    hit = !HOST_CHIP_SELECT_ZERO_B && (rd || wr) // RULE_10
          && !CARD_BUFFER_GATE // RULE_11
          && mode != MODE_NONE
          && reg_listed(HOST_ADDR, rd); // RULE_12
  end

  always_comb begin
    ctl_next = CTL_IDLE; // RULE_12
    if (hit) begin
      ctl_next.ce2_b = HOST_ADDR[CE2_POS]; // RULE_04 RULE_06 RULE_07
      ctl_next.ce1_b = HOST_ADDR[CE1_POS]; // RULE_04
      ctl_next.reg_b = HOST_ADDR[REG_POS]; // RULE_04
      ctl_next.addr = {HOST_ADDR[WORD_MSB:WORD_LSB], // RULE_04
        HOST_ADDR[A0_POS]};
      unique case (mode)
        MODE_MEM: begin
          ctl_next.oe_b = !rd; // RULE_02
          ctl_next.we_b = !wr; // RULE_02
        end
        MODE_IO: begin
          ctl_next.iord_b = !rd; // RULE_03
          ctl_next.iowr_b = !wr; // RULE_03
        end
        default: ctl_next = CTL_IDLE;
      endcase
    end
  end

  // data lanes registered too: card write data lines up with the strobes, host read data comes one clock after them
  always_comb begin
    host_dout_next = swap_lanes(CARD_D_IN); // RULE_08 RULE_09
    host_doe_b_next = !(hit && rd);
    card_dout_next = swap_lanes(HOST_D_IN); // RULE_08 RULE_09
    card_doe_b_next = !(hit && wr);
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      ctl_reg <= CTL_IDLE;
      host_dout_reg <= 16'h0000;
      host_doe_b_reg <= 1'b1;
      card_dout_reg <= 16'h0000;
      card_doe_b_reg <= 1'b1;
    end else begin
      ctl_reg <= ctl_next;
      host_dout_reg <= host_dout_next;
      host_doe_b_reg <= host_doe_b_next;
      card_dout_reg <= card_dout_next;
      card_doe_b_reg <= card_doe_b_next;
    end
  end

  assign CARD_CTL = ctl_reg;
  assign HOST_D_OUT = host_dout_reg;
  assign HOST_D_OE_B = host_doe_b_reg;
  assign CARD_D_OUT = card_dout_reg;
  assign CARD_D_OE_B = card_doe_b_reg;

  property p_mem_read;
    @(posedge MCLK) disable iff (!RST_B)
    (hit && mode == MODE_MEM && rd) |=> (!CARD_CTL.oe_b && CARD_CTL.we_b
      && CARD_CTL.iord_b && CARD_CTL.iowr_b && CARD_CTL.reg_b);
  endproperty
  a_mem_read: assert property (p_mem_read) // RULE_02
    else $error("memory read strobes wrong");

  property p_mem_write;
    @(posedge MCLK) disable iff (!RST_B)
    (hit && mode == MODE_MEM && wr) |=> (CARD_CTL.oe_b && !CARD_CTL.we_b
      && CARD_CTL.iord_b && CARD_CTL.iowr_b && CARD_CTL.reg_b
      && !CARD_D_OE_B);
  endproperty
  a_mem_write: assert property (p_mem_write) // RULE_02
    else $error("memory write strobes wrong");

  property p_io_read;
    @(posedge MCLK) disable iff (!RST_B)
    (hit && mode == MODE_IO && rd) |=> (!CARD_CTL.iord_b && CARD_CTL.iowr_b
      && CARD_CTL.oe_b && CARD_CTL.we_b && !CARD_CTL.reg_b && !HOST_D_OE_B);
  endproperty
  a_io_read: assert property (p_io_read) // RULE_03
    else $error("io read strobes wrong");

  property p_io_write;
    @(posedge MCLK) disable iff (!RST_B)
    (hit && mode == MODE_IO && wr) |=> (CARD_CTL.iord_b && !CARD_CTL.iowr_b
      && CARD_CTL.oe_b && CARD_CTL.we_b && !CARD_CTL.reg_b);
  endproperty
  a_io_write: assert property (p_io_write) // RULE_03
    else $error("io write strobes wrong");

  property p_addr_map;
    @(posedge MCLK) disable iff (!RST_B)
    hit |=> (CARD_CTL.addr == {$past(HOST_ADDR[WORD_MSB:WORD_LSB]),
      $past(HOST_ADDR[A0_POS])});
  endproperty
  a_addr_map: assert property (p_addr_map) // RULE_04
    else $error("card address not taken from host address");

  property p_wide;
    @(posedge MCLK) disable iff (!RST_B)
    (hit && HOST_ADDR[10:1] <= W_CYL && !HOST_ADDR[11])
      |=> (!CARD_CTL.ce1_b && !CARD_CTL.ce2_b);
  endproperty
  a_wide: assert property (p_wide) // RULE_06
    else $error("16-bit register did not get both enables");

  property p_narrow;
    @(posedge MCLK) disable iff (!RST_B)
    (hit && (HOST_ADDR[11] || HOST_ADDR[10:1] >= W_HEAD))
      |=> (!CARD_CTL.ce1_b && CARD_CTL.ce2_b);
  endproperty
  a_narrow: assert property (p_narrow) // RULE_07
    else $error("8-bit register enables wrong");

  property p_swap;
    @(posedge MCLK) disable iff (!RST_B)
    1'b1 |=> (HOST_D_OUT == {$past(CARD_D_IN[7:0]), $past(CARD_D_IN[15:8])}
      && CARD_D_OUT == {$past(HOST_D_IN[7:0]), $past(HOST_D_IN[15:8])});
  endproperty
  a_swap: assert property (p_swap) // RULE_08 RULE_09
    else $error("byte lanes not crossed");

  property p_idle;
    @(posedge MCLK) disable iff (!RST_B)
    (!hit || CARD_BUFFER_GATE || HOST_CHIP_SELECT_ZERO_B)
      |=> (CARD_CTL.ce1_b && CARD_CTL.ce2_b && CARD_CTL.oe_b
      && CARD_CTL.we_b && CARD_CTL.iord_b && CARD_CTL.iowr_b
      && HOST_D_OE_B && CARD_D_OE_B);
  endproperty
  a_idle: assert property (p_idle) // RULE_12 RULE_11 RULE_10
    else $error("card signals active without a listed access");

  property p_mode_window;
    @(posedge MCLK) disable iff (!RST_B)
    (hit && HOST_ADDR[31:12] == MEM_BASE[31:12]) |-> mode == MODE_MEM;
  endproperty
  a_mode_window: assert property (p_mode_window) // RULE_01
    else $error("memory window not decoded as memory mode");

  property p_io_window;
    @(posedge MCLK) disable iff (!RST_B)
    (hit && HOST_ADDR[31:12] == IO_BASE[31:12]) |-> mode == MODE_IO;
  endproperty
  a_io_window: assert property (p_io_window) // RULE_01
    else $error("io window not decoded as io mode");
endmodule

// File: cad_decoder_tb.sv
/*
 * Self-checking bench for the card address decoder: drive-register
 * table in both modes, lane swap, refusals and reset state.
 * Assumes the card model answers reads on the same clock.
 */
`timescale 1ns/1ps
module cad_decoder_tb;
  import cad_pkg::*;
  logic MCLK = 0, RST_B = 0, cs_b = 1, rd_b = 1, wr_b = 1, gate = 1;
  logic g_cs = 0, g_both = 0, g_gate = 0, hoe_b, coe_b;
  logic [31:0] addr = 0;
  logic [15:0] hd = 0, cd_in, hd_out, cd_out, c;
  cad_card_ctl_t ctl, ex;
  int failures = 0, check_count = 0, cyc = 0;
  logic [31:0] tbl [8] = '{32'h285000, 32'h295800, 32'h285002,
    32'h285004, 32'h295006, 32'h295806, 32'h29500e, 32'h29580e};
  cad_decoder uut (.MCLK(MCLK), .RST_B(RST_B),
    .HOST_CHIP_SELECT_ZERO_B(cs_b), .HOST_RD_B(rd_b), .HOST_WR_B(wr_b),
    .HOST_ADDR(addr), .HOST_D_IN(hd), .HOST_D_OUT(hd_out),
    .HOST_D_OE_B(hoe_b), .CARD_BUFFER_GATE(gate), .CARD_CTL(ctl),
    .CARD_D_IN(cd_in), .CARD_D_OUT(cd_out), .CARD_D_OE_B(coe_b));
  cad_card_model card (.clk(MCLK), .ctl(ctl), .d_out(cd_in));
  always #5 MCLK = ~MCLK;
  // ceiling well above the hundred or so cycles the run needs
  always @(posedge MCLK) begin
    cyc++;
    if (cyc > 2000) begin
      failures++;
      conclude();
    end
  end
  task chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task acc(input logic [31:0] a, input logic w, input logic ok);
    logic [15:0] d;
    d = a[15:0] ^ 16'h3c5a;
    @(negedge MCLK);
    addr = a;
    hd = d;
    cs_b = g_cs;
    gate = g_gate;
    rd_b = w || g_both;
    wr_b = !w || g_both;
    ex = CTL_IDLE;
    if (ok) begin
      ex.ce2_b = a[16];
      ex.ce1_b = a[15];
      ex.reg_b = a[12];
      ex.addr = {a[10:1], a[11]};
      if (a[14]) begin
        ex.oe_b = w;
        ex.we_b = !w;
      end else begin
        ex.iord_b = w;
        ex.iowr_b = !w;
      end
    end
    @(posedge MCLK);
    #1;
    chk(ctl[11:0] === ex[11:0], "reg and address");
    chk(ctl[17:16] === ex[17:16], "enables");
    chk(ctl === ex, "card controls");
    chk(coe_b === !(ok && w), "card bus enable");
    chk(hoe_b === !(ok && !w), "host bus enable");
    if (ok && w)
      chk(cd_out === {d[7:0], d[15:8]}, "write lanes");
    if (ok && !w) begin
      c = {5'h1a, ex.addr};
      @(posedge MCLK);
      #1;
      chk(hd_out === {c[7:0], c[15:8]}, "read lanes");
    end
    @(negedge MCLK);
    cs_b = 1;
    rd_b = 1;
    wr_b = 1;
    @(posedge MCLK);
    #1;
    chk(ctl === CTL_IDLE && coe_b === 1 && hoe_b === 1, "idle");
  endtask
  task t_reset;
    repeat (5) @(posedge MCLK);
    #1;
    chk(ctl === CTL_IDLE, "reset ctl");
    chk(hoe_b === 1'b1 && coe_b === 1'b1, "reset enables");
    chk(hd_out === 16'h0000 && cd_out === 16'h0000, "reset data");
    @(negedge MCLK);
    RST_B = 1;
    gate = 0;
  endtask
  // drive address write is refused: only its read is listed
  task t_table;
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 16; i++)
        acc(tbl[i / 2] - m * 32'h3000, i[0], i != 15);
  endtask
  task t_refuse;
    acc(32'h285800, 0, 0);
    acc(32'h285010, 1, 0);
    acc(32'h284000, 0, 0);
    acc(32'h385000, 1, 0);
    g_gate = 1;
    acc(32'h285000, 0, 0);
    g_gate = 0;
    g_cs = 1;
    acc(32'h282000, 1, 0);
    g_cs = 0;
    g_both = 1;
    acc(32'h282002, 0, 0);
    g_both = 0;
    acc(32'h292806, 1, 1);
  endtask
  task conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    t_reset();
    t_table();
    t_refuse();
    conclude();
  end
endmodule
